/* File: bench/dpc_counter_properties.sv */
`timescale 1ns/1ps
module dpc_counter_properties
  import dpc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  match_out_pin
);
  logic [15:0] cmd_q;
  logic [1:0]  moe_d;
  logic [1:0]  rel_d;
  wire  [1:0]  moe = {cmd_q[CH2_SHIFT+CB_MOE], cmd_q[CB_MOE]};
  // Pin may drop on a clear or when its enable goes away
  wire  [1:0]  rel = {cmd_q[CH2_SHIFT+CB_MCLR], cmd_q[CB_MCLR]} | ~moe;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_q <= 16'h0000;
      moe_d <= 2'h0;
      rel_d <= 2'h0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == {22'h000000, IDX_CMD, 2'b00})
        cmd_q <= pwdata[15:0];
      moe_d <= moe;
      rel_d <= rel;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
  property p_err; pslverr == 1'b0; endproperty
  a_err: assert property (p_err) else $error("slave error raised");
  property p_moe; (match_out_pin & ~(moe | moe_d)) == 2'b00; endproperty
  a_moe: assert property (p_moe) else $error("match pin without enable");
  property p_hold; (~match_out_pin & $past(match_out_pin) & ~(rel | rel_d)) == 2'b00; endproperty
  a_hold: assert property (p_hold) else $error("match pin dropped early");
  property p_rpin; $fell(rst) |-> match_out_pin == 2'b00; endproperty
  a_rpin: assert property (p_rpin) else $error("match pin set after reset");
  property p_cmp; pready && !pwrite && paddr == {22'h000000, IDX_STAT, 2'b00}
    |-> !(prdata[SB_GT] && prdata[SB_LT]) && !(prdata[4+SB_GT] && prdata[4+SB_LT]); endproperty
  a_cmp: assert property (p_cmp) else $error("greater and less together");
  property p_wid; pready && !pwrite && paddr == {22'h000000, IDX_PRESET_1, 2'b00}
    |-> prdata[31:24] == 8'h00; endproperty
  a_wid: assert property (p_wid) else $error("preset wider than 24 bits");
endmodule
bind dpc_counter dpc_counter_properties u_props (.*);

/* File: bench/dpc_counter_tb_top.sv */
`timescale 1ns/1ps
module dpc_counter_tb_top
  import dpc_pkg::*;
;
  logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic        pready, pslverr;
  logic [1:0]  phase_a, phase_b, match_out_pin, ext_preset_pin = 2'b00, ext_inhibit_pin = 2'b00;
  int          bad_count = 0, num_checks = 0, cyc = 0;
  always #50 ref_clk = ~ref_clk;
  dpc_encoder u_enc (.ref_clk(ref_clk), .phase_a(phase_a), .phase_b(phase_b));
  dpc_counter u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phase_a(phase_a), .phase_b(phase_b), .ext_preset_pin(ext_preset_pin),
    .ext_inhibit_pin(ext_inhibit_pin), .match_out_pin(match_out_pin));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(logic w, logic [7:0] idx, logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {22'h000000, idx, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] idx, logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, idx, d, q);
  endtask
  task automatic rchk(string n, logic [7:0] idx, logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, idx, 32'h0, q);
    chk(n, e, q);
  endtask
  // Capture needs a rising edge, so pulse the bit over the base command
  task automatic cap(logic [31:0] b, logic [31:0] e);
    wr(IDX_CMD, b | 32'h20);
    wr(IDX_CMD, b);
    rchk("pv1", IDX_PV_1, e);
  endtask
  task automatic s_init();
    rchk("stat", IDX_STAT, 32'h22);
    wr(IDX_SET_1, 32'h10);
    wr(IDX_CMD, 32'h101);
    wr(IDX_CMD, 32'h0);
    rchk("stat", IDX_STAT, 32'h24);
    wr(IDX_PRESET_1, 32'hAB000100);
    rchk("preset1", IDX_PRESET_1, 32'h100);
    wr(IDX_CMD, 32'h2);
    cap(32'h0, 32'h100);
    rchk("stat", IDX_STAT, 32'h21);
  endtask
  task automatic s_count();
    wr(IDX_MODE, 32'h8);
    wr(IDX_CMD, 32'h10);
    u_enc.pulse(0, 0, 0);
    cap(32'h10, 32'h102);
    wr(IDX_CMD, 32'h18);
    u_enc.pulse(0, 0, 0);
    cap(32'h18, 32'h100);
    wr(IDX_MODE, 32'h12);
    wr(IDX_CMD, 32'h10);
    u_enc.pulse(0, 1, 0);
    cap(32'h10, 32'h104);
    u_enc.pulse(0, 1, 1);
    cap(32'h10, 32'h100);
    ext_inhibit_pin <= 2'b01;
    u_enc.pulse(0, 1, 0);
    cap(32'h10, 32'h100);
    ext_inhibit_pin <= 2'b00;
    wr(IDX_CMD, 32'h0);
    u_enc.pulse(0, 1, 0);
    cap(32'h0, 32'h100);
  endtask
  task automatic s_ext();
    wr(IDX_MODE, 32'h8);
    wr(IDX_CMD, 32'h10);
    u_enc.pulse(0, 0, 0);
    ext_preset_pin <= 2'b01;
    cap(32'h10, 32'h100);
    rchk("stat", IDX_STAT, 32'h29);
    ext_preset_pin <= 2'b00;
    u_enc.pulse(0, 0, 0);
    ext_preset_pin <= 2'b01;
    cap(32'h10, 32'h102);
    wr(IDX_CMD, 32'h50);
    wr(IDX_CMD, 32'h10);
    rchk("stat", IDX_STAT, 32'h21);
    ext_preset_pin <= 2'b00;
  endtask
  task automatic s_ring();
    wr(IDX_SET_1, 32'h104);
    wr(IDX_RING, 32'h1);
    u_enc.pulse(0, 0, 0);
    cap(32'h10, 32'h100);
    chk("pin", 32'h0, {31'h0, match_out_pin[0]});
    wr(IDX_CMD, 32'h14);
    repeat (2) @(posedge ref_clk);
    chk("pin", 32'h1, {31'h0, match_out_pin[0]});
    wr(IDX_CMD, 32'h15);
    wr(IDX_CMD, 32'h14);
    repeat (2) @(posedge ref_clk);
    chk("pin", 32'h0, {31'h0, match_out_pin[0]});
    wr(IDX_CMD, 32'h400);
    repeat (2) @(posedge ref_clk);
    chk("pin2", 32'h1, {31'h0, match_out_pin[1]});
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    s_init();
    s_count();
    s_ext();
    s_ring();
    conclude();
  end
endmodule

/* File: bench/dpc_encoder.sv */
`timescale 1ns/1ps
module dpc_encoder (
  input  wire logic       ref_clk,
  output logic      [1:0] phase_a,
  output logic      [1:0] phase_b
);
  initial begin
    phase_a = 2'b00;
    phase_b = 2'b00;
  end
  // Four steps a period; swapping A and B reverses direction
  task automatic pulse(input int ch, input bit quad, input bit rev);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      phase_a[ch] <= (quad && rev) ? (i == 1 || i == 2) : (i < 2);
      phase_b[ch] <= quad && (rev ? (i < 2) : (i == 1 || i == 2));
      repeat (2) @(posedge ref_clk);
    end
  endtask
endmodule

/* File: inc/dpc_pkg.sv */
package dpc_pkg;
  localparam int          DATA_W        = 24;
  localparam logic [23:0] CNT_ZERO      = 24'h000000;
  localparam logic [23:0] STEP_ONE      = 24'h000002;
  localparam logic [23:0] STEP_QUAD     = 24'h000001;
  // Printed offsets are word indexes, so byte address is four times the index
  localparam logic [7:0]  IDX_PRESET_1  = 8'h01;
  localparam logic [7:0]  IDX_PRESET_2  = 8'h21;
  localparam logic [7:0]  IDX_SET_1     = 8'h03;
  localparam logic [7:0]  IDX_SET_2     = 8'h23;
  localparam logic [7:0]  IDX_PV_1      = 8'h05;
  localparam logic [7:0]  IDX_PV_2      = 8'h25;
  localparam logic [7:0]  IDX_MODE      = 8'h40;
  localparam logic [7:0]  IDX_CMD       = 8'h41;
  localparam logic [7:0]  IDX_STAT      = 8'h42;
  localparam logic [7:0]  IDX_RING      = 8'h43;
  localparam logic [7:0]  MODE_ONE      = 8'h08;
  localparam logic [7:0]  MODE_TWO      = 8'h12;
  // Command bit positions within a channel byte
  localparam int          CB_MCLR       = 0;
  localparam int          CB_LOAD       = 1;
  localparam int          CB_MOE        = 2;
  localparam int          CB_DOWN       = 3;
  localparam int          CB_EN         = 4;
  localparam int          CB_CAP        = 5;
  localparam int          CB_XCLR       = 6;
  localparam int          CH2_SHIFT     = 8;
  // Status bit positions within a channel nibble
  localparam int          SB_GT         = 0;
  localparam int          SB_EQ         = 1;
  localparam int          SB_LT         = 2;
  localparam int          SB_XP         = 3;
  localparam logic [31:0] RD_ZERO       = 32'h00000000;

  typedef struct packed {
    logic [23:0] cnt;
    logic [23:0] preset;
    logic [23:0] setv;
    logic [23:0] pv;
    logic        eq_latch;
    logic        xp_latch;
    logic        load_d;
    logic        cap_d;
    logic        xpin_d;
    logic        a_d;
    logic        b_d;
    logic        match_out;
  } dpc_chan_s;

  typedef struct packed {
    dpc_chan_s [1:0] ch;
    logic [7:0]      mode;
    logic [15:0]     cmd;
    logic [1:0]      ring;
    logic [31:0]     prdata;
    logic            pready;
  } dpc_state_s;
endpackage

/* File: logic/dpc_counter.sv */
// Operation
// - Single-phase: each phase A pulse changes count by two.
// - Two-phase: each quadrature pulse period changes count by four.
// - Each counter is an unsigned 24-bit value.
// - Single-phase counts down while down command set, else up.
// - Two-phase: B leading A decrements, A leading B increments.
// - Preset is 24-bit word at index 1 (ch1) and 33 (ch2).
// - Rising edge of load command copies preset into counter.
// - External preset pin leading edge presets and sets latch.
// - While latch set, further external preset edges are ignored.
// - Preset clear command clears latch even with pin still active.
// - Counting happens only while count enable is set.
// - External inhibit pin stops counting regardless of commands.
// - Ring option presets counter whenever it equals set value.
// - Match pin active on equality only while output enable set.
// - Greater flag set while count exceeds set value.
// - Less flag set while count is below set value.
// - Match flag and pin latch until match clear command.
// - External preset seen flag latches until preset clear command.
// - After reset match is set since both are zero; re-latches.
// - Rising edge of capture request copies count to present value.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module dpc_counter
  import dpc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  phase_a,
  input  wire logic [1:0]  phase_b,
  input  wire logic [1:0]  ext_preset_pin,
  input  wire logic [1:0]  ext_inhibit_pin,
  output logic      [1:0]  match_out_pin
);

  dpc_state_s st;
  dpc_state_s next_st;

  function automatic logic [23:0] step_of(input logic two_phase, input logic a_edge,
                                          input logic b_edge);
    // Quadrature: four edges per period, one count each; single: two per pulse
    if (two_phase) begin
      step_of = (a_edge || b_edge) ? STEP_QUAD : CNT_ZERO;
    end else begin
      step_of = a_edge ? STEP_ONE : CNT_ZERO;
    end
  endfunction

  function automatic logic [7:0] word_idx(input logic [31:0] addr);
    word_idx = addr[9:2];
  endfunction

  // Command bit of one channel; the second channel sits one byte higher
  function automatic logic cmd_bit(input logic [15:0] cmd, input int c, input int pos);
    cmd_bit = cmd[c*CH2_SHIFT+pos];
  endfunction

  function automatic logic rose(input logic now, input logic prev);
    rose = now && !prev;
  endfunction

  function automatic logic changed(input logic now, input logic prev);
    changed = now ^ prev;
  endfunction

  // Set wins, so an event in the clear cycle is never lost
  function automatic logic latch_next(input logic cur, input logic set, input logic clr);
    if (set) begin
      latch_next = 1'b1;
    end else if (clr) begin
      latch_next = 1'b0;
    end else begin
      latch_next = cur;
    end
  endfunction

  // Direction from which phase moved against the level of the other
  function automatic logic quad_down(input logic a, input logic b, input logic a_moved);
    if (a_moved) begin
      quad_down = (a == b);
    end else begin
      quad_down = (a != b);
    end
  endfunction

  // Wraps modulo the counter width, no saturation
  function automatic logic [23:0] count_next(input logic [23:0] cnt, input logic [23:0] step,
                                             input logic down);
    if (down) begin
      count_next = 24'(cnt - step);
    end else begin
      count_next = 24'(cnt + step);
    end
  endfunction

  function automatic logic [3:0] status_of(input dpc_chan_s ch);
    status_of        = 4'h0;
    status_of[SB_GT] = ch.cnt > ch.setv;
    status_of[SB_EQ] = ch.eq_latch;
    status_of[SB_LT] = ch.cnt < ch.setv;
    status_of[SB_XP] = ch.xp_latch;
  endfunction

  function automatic logic [31:0] word24(input logic [23:0] v);
    word24 = {8'h00, v};
  endfunction

  // Preset load overrides counting in the same cycle
  function automatic dpc_chan_s chan_next(input dpc_chan_s cur, input logic [15:0] cmd,
                                          input int c, input logic two_phase,
                                          input logic ring, input logic a, input logic b,
                                          input logic xpin, input logic inhibit);
    dpc_chan_s   nxt;
    logic        a_edge;
    logic        b_edge;
    logic        down;
    logic        run;
    logic        xp_edge;
    logic        do_load;
    logic        cur_eq;
    logic [23:0] step;
    nxt    = cur;
    a_edge = changed(a, cur.a_d);
    b_edge = changed(b, cur.b_d);
    if (two_phase) begin
      down = quad_down(a, b, a_edge);
    end else begin
      // Rising edges only; the doubled step gives two counts a pulse
      a_edge = rose(a, cur.a_d);
      b_edge = 1'b0;
      down   = cmd_bit(cmd, c, CB_DOWN);
    end
    step    = step_of(two_phase, a_edge, b_edge);
    run     = cmd_bit(cmd, c, CB_EN) && !inhibit;
    xp_edge = rose(xpin, cur.xpin_d) && !cur.xp_latch;
    do_load = rose(cmd_bit(cmd, c, CB_LOAD), cur.load_d) || xp_edge;
    cur_eq  = (cur.cnt == cur.setv);
    if (ring && cur_eq) begin
      do_load = 1'b1;
    end
    if (do_load) begin
      nxt.cnt = cur.preset;
    end else if (run) begin
      nxt.cnt = count_next(cur.cnt, step, down);
    end
    nxt.a_d       = a;
    nxt.b_d       = b;
    nxt.xpin_d    = xpin;
    nxt.load_d    = cmd_bit(cmd, c, CB_LOAD);
    nxt.cap_d     = cmd_bit(cmd, c, CB_CAP);
    nxt.xp_latch  = latch_next(cur.xp_latch, xp_edge, cmd_bit(cmd, c, CB_XCLR));
    nxt.eq_latch  = latch_next(cur.eq_latch, cur_eq, cmd_bit(cmd, c, CB_MCLR));
    nxt.match_out = nxt.eq_latch && cmd_bit(cmd, c, CB_MOE);
    if (rose(cmd_bit(cmd, c, CB_CAP), cur.cap_d)) begin
      nxt.pv = cur.cnt;
    end
    chan_next = nxt;
  endfunction

  // Unmapped writes are dropped without an error
  function automatic dpc_state_s apply_write(input dpc_state_s s, input logic [7:0] idx,
                                             input logic [31:0] data);
    apply_write = s;
    case (idx)
      IDX_PRESET_1: apply_write.ch[0].preset = data[23:0];
      IDX_PRESET_2: apply_write.ch[1].preset = data[23:0];
      IDX_SET_1:    apply_write.ch[0].setv   = data[23:0];
      IDX_SET_2:    apply_write.ch[1].setv   = data[23:0];
      IDX_MODE:     apply_write.mode         = data[7:0];
      IDX_CMD:      apply_write.cmd          = data[15:0];
      IDX_RING:     apply_write.ring         = data[1:0];
      default: ;
    endcase
  endfunction

  function automatic logic [31:0] read_word(input dpc_state_s s, input logic [7:0] idx);
    case (idx)
      IDX_PRESET_1: read_word = word24(s.ch[0].preset);
      IDX_PRESET_2: read_word = word24(s.ch[1].preset);
      IDX_SET_1:    read_word = word24(s.ch[0].setv);
      IDX_SET_2:    read_word = word24(s.ch[1].setv);
      IDX_PV_1:     read_word = word24(s.ch[0].pv);
      IDX_PV_2:     read_word = word24(s.ch[1].pv);
      IDX_MODE:     read_word = {24'h000000, s.mode};
      IDX_CMD:      read_word = {16'h0000, s.cmd};
      IDX_STAT:     read_word = {24'h000000, status_of(s.ch[1]), status_of(s.ch[0])};
      IDX_RING:     read_word = {30'h00000000, s.ring};
      default:      read_word = RD_ZERO;
    endcase
  endfunction

  logic        acc;
  logic        wr;
  logic [7:0]  idx;
  logic        two_phase;

  always_comb begin
    next_st        = st;
    acc            = psel && penable;
    wr             = acc && pwrite;
    idx            = word_idx(paddr);
    two_phase      = (st.mode == MODE_TWO);
    // Ready and read data both load at the setup edge, so they stand together
    next_st.pready = psel && !penable;
    next_st.prdata = RD_ZERO;

    for (int c = 0; c < 2; c++) begin
      next_st.ch[c] = chan_next(st.ch[c], st.cmd, c, two_phase, st.ring[c], phase_a[c],
                                phase_b[c], ext_preset_pin[c], ext_inhibit_pin[c]);
    end

    if (wr) begin
      next_st = apply_write(next_st, idx, pwdata);
    end
    if (psel && !penable && !pwrite) begin
      next_st.prdata = read_word(st, idx);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata        = st.prdata;
  assign pready        = st.pready;
  assign pslverr       = 1'b0;
  assign match_out_pin = {st.ch[1].match_out, st.ch[0].match_out};

endmodule
